/* File: core/nvm_param_access.v */
// parameter store with shadow registers, key-gated mass read and mass write
//
// Behaviour
// RULE1 - A 112-bit store of seven 16-bit words is kept, each word mirrored by a shadow register.
// RULE2 - The host powers up, leaves sleep and waits 10 ms before its first register write.
// RULE3 - The host sets the driver disable bit at driver_disable_control and the power stage stops being driven.
// RULE4 - Store operations run only after 0x0000 and then 0xC0DE are written to the key at eeprom_access_key.
// RULE5 - The ready flag in eeprom_ready_status shows readiness and the host polls it before and after an operation.
// RULE6 - A write of mass mode with write select 1 to eeprom_operation_control copies all shadow words into the store.
// RULE7 - A write of mass mode with write select 0 to eeprom_operation_control loads every store word into its shadow.
// RULE8 - The host clears the driver disable bit afterwards and motor driving resumes.
// RULE9 - The host programs only with the motor at rest, cycles power and reads back to verify.
// RULE10 - Resistance sits in bits 6:0 of the first word and velocity in bits 6:0 of the second.
// RULE11 - The resistance value is mantissa shifted left by shift, in units of 9.67 milliohm.
// RULE12 - Code 0x7F decodes to 1920 and the resistance never decodes below 3.
// RULE13 - Ready reads 0 during an operation and new operation requests are ignored meanwhile.
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_regs.vh"

module nvm_param_access #(
  parameter WORD_WRITE_CYCLES = `WORD_WRITE_CYCLES_DEF,
  parameter WORD_READ_CYCLES  = `WORD_READ_CYCLES_DEF
) (
  input  wire        mclk,
  input  wire        srst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output wire        driver_stage_enable,
  output wire        nvm_ready_flag,
  output reg  [10:0] resistance_dig,
  output reg  [10:0] velocity_dig
);

  // ----------------------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_WRITE = 2'h1;
  localparam ST_READ  = 2'h2;

  // the counts are worked out at full width, then cut to the counter widths on purpose
  localparam integer LAST_IDX_I = `NVM_WORDS - 1;
  localparam integer WR_WAIT_I  = WORD_WRITE_CYCLES - 1;
  localparam integer RD_WAIT_I  = WORD_READ_CYCLES - 1;

  localparam [2:0]   LAST_IDX   = LAST_IDX_I[2:0];
  localparam [7:0]   WR_WAIT    = WR_WAIT_I[7:0];
  localparam [7:0]   RD_WAIT    = RD_WAIT_I[7:0];

  // ----------------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------------
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [2:0]  word_idx_r;
  reg  [2:0]  word_idx_nxt;
  reg  [7:0]  wait_cnt_r;
  reg  [7:0]  wait_cnt_nxt;
  reg  [15:0] access_key_r;
  reg         key_cleared_r;
  reg         unlocked_r;
  reg  [15:0] control_r;
  reg  [15:0] driver_disable_r;
  reg         stage_enable_r;
  reg         ready_r;

  wire        busy;
  wire        word_done;
  wire        host_wr_key;
  wire        host_wr_ctrl;
  wire        host_wr_shadow;
  wire        shadow_hit;
  wire [2:0]  shadow_idx;
  wire        op_request;
  wire        op_accept;
  wire        mode_is_mass;
  wire [10:0] resistance_raw;
  wire [10:0] velocity_raw;
  wire [`NVM_TOTAL_BITS-1:0] shadow_flat;

  // ----------------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------------
  assign busy           = (state_r != ST_IDLE);
  assign nvm_ready_flag = ready_r; // see RULE5
  assign host_wr_key    = reg_wr && (reg_addr == `OFS_EEPROM_ACCESS_KEY);
  assign host_wr_ctrl   = reg_wr && (reg_addr == `OFS_EEPROM_OPERATION_CONTROL);
  // the seven shadow words sit on consecutive offsets, so the low address bits index them
  assign shadow_hit     = (reg_addr >= `OFS_SHADOW_CONFIG_WORD_FIRST)
                          && (reg_addr <= `OFS_SHADOW_CONFIG_WORD_LAST);
  assign host_wr_shadow = reg_wr && shadow_hit;
  assign shadow_idx     = reg_addr[2:0];

  // only mass mode with shadow enable and reload both clear starts a transfer
  assign mode_is_mass = (reg_wdata[`ACCESS_MODE_MSB:`ACCESS_MODE_LSB] == `ACCESS_MODE_MASS)
                        && !reg_wdata[`SHADOW_ENABLE_BIT]
                        && !reg_wdata[`RELOAD_BIT];
  assign op_request   = host_wr_ctrl && mode_is_mass;
  assign op_accept    = op_request && unlocked_r && !busy; // see RULE4, RULE13

  // ----------------------------------------------------------------------------
  // access key
  // ----------------------------------------------------------------------------
  // any key write other than the exact pair relocks, so a stray write cannot unlock
  always @(posedge mclk) begin
    if (srst) begin
      access_key_r  <= `RST_WORD;
      key_cleared_r <= 1'b0;
      unlocked_r    <= 1'b0;
    end else if (host_wr_key) begin
      access_key_r <= reg_wdata;
      if (reg_wdata == `KEY_CLEAR_VALUE) begin
        key_cleared_r <= 1'b1; // see RULE4
        unlocked_r    <= 1'b0;
      end else if ((reg_wdata == `KEY_UNLOCK_VALUE) && key_cleared_r) begin
        key_cleared_r <= 1'b0;
        unlocked_r    <= 1'b1; // see RULE4
      end else begin
        key_cleared_r <= 1'b0;
        unlocked_r    <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // control and driver disable registers
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      control_r        <= `RST_WORD;
      driver_disable_r <= `RST_DRIVER_DISABLE;
      stage_enable_r   <= 1'b1;
    end else begin
      if (host_wr_ctrl && !busy) begin
        control_r <= reg_wdata & `CONTROL_USED_MASK;
      end
      if (reg_wr && (reg_addr == `OFS_DRIVER_DISABLE_CONTROL)) begin
        driver_disable_r <= {15'h0000, reg_wdata[`DRIVER_DISABLE_BIT]};
        stage_enable_r   <= ~reg_wdata[`DRIVER_DISABLE_BIT]; // see RULE3, RULE8
      end
    end
  end

  // the power stage enable is the inverse of the disable bit, kept in its own flip-flop
  assign driver_stage_enable = stage_enable_r; // see RULE3, RULE8

  // ----------------------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------------------
  assign word_done = (state_r == ST_WRITE) ? (wait_cnt_r == WR_WAIT)
                                           : (wait_cnt_r == RD_WAIT);

  always @* begin
    state_nxt    = state_r;
    word_idx_nxt = word_idx_r;
    wait_cnt_nxt = wait_cnt_r;
    case (state_r)
      ST_IDLE: begin
        word_idx_nxt = 3'h0;
        wait_cnt_nxt = 8'h00;
        if (op_accept) begin
          if (reg_wdata[`WRITE_SELECT_BIT]) begin
            state_nxt = ST_WRITE; // see RULE6
          end else begin
            state_nxt = ST_READ; // see RULE7
          end
        end
      end
      ST_WRITE, ST_READ: begin
        if (word_done) begin
          wait_cnt_nxt = 8'h00;
          if (word_idx_r == LAST_IDX) begin
            state_nxt    = ST_IDLE; // see RULE5
            word_idx_nxt = 3'h0;
          end else begin
            word_idx_nxt = word_idx_r + 3'h1;
          end
        end else begin
          wait_cnt_nxt = wait_cnt_r + 8'h01;
        end
      end
      default: begin
        state_nxt    = ST_IDLE;
        word_idx_nxt = 3'h0;
        wait_cnt_nxt = 8'h00;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (srst) begin
      state_r    <= ST_IDLE;
      word_idx_r <= 3'h0;
      wait_cnt_r <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      word_idx_r <= word_idx_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // ready comes from a flip-flop so the status pin cannot glitch while the state code moves
  always @(posedge mclk) begin
    if (srst) begin
      ready_r <= 1'b1;
    end else begin
      ready_r <= (state_nxt == ST_IDLE); // see RULE5, RULE13
    end
  end

  // ----------------------------------------------------------------------------
  // shadow registers and store words
  // ----------------------------------------------------------------------------
  // each word owns its own pair of flip-flops, so no storage element has two drivers;
  // the flat bus gives the read-back and decode paths an index into the shadow words
  // the store words have no reset: srst models a logic reset, not an erase
  genvar gi;
  generate
    for (gi = 0; gi < `NVM_WORDS; gi = gi + 1) begin : g_word
      wire        slot_end;
      wire        host_load;
      reg  [15:0] shadow_word_r;
      reg  [15:0] store_word_r;

      assign slot_end  = word_done && (word_idx_r == gi);
      assign host_load = host_wr_shadow && !busy && (shadow_idx == gi);

      always @(posedge mclk) begin
        if (srst) begin
          shadow_word_r <= `RST_WORD;
        end else if ((state_r == ST_READ) && slot_end) begin
          shadow_word_r <= store_word_r; // see RULE7
        end else if (host_load) begin
          // host writes during a transfer are dropped to keep the copy coherent
          shadow_word_r <= reg_wdata; // see RULE1, RULE13
        end
      end

      always @(posedge mclk) begin
        if ((state_r == ST_WRITE) && slot_end) begin
          store_word_r <= shadow_word_r; // see RULE6, RULE1
        end
      end

      assign shadow_flat[gi*`NVM_WORD_BITS +: `NVM_WORD_BITS] = shadow_word_r;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // motor parameter decode
  // ----------------------------------------------------------------------------
  param_field_decode u_resistance_decode (
    .field_code    (shadow_flat[`PARAM_FIELD_MSB:0]),
    .digital_value (resistance_raw)
  );

  param_field_decode u_velocity_decode (
    .field_code    (shadow_flat[`NVM_WORD_BITS+`PARAM_FIELD_MSB:`NVM_WORD_BITS]),
    .digital_value (velocity_raw)
  );

  // resistance values below the supported floor are raised to it rather than passed as near-zero; velocity passes unclamped
  always @(posedge mclk) begin
    if (srst) begin
      resistance_dig <= `RESISTANCE_DIG_MIN;
      velocity_dig   <= 11'h000;
    end else begin
      if (resistance_raw < `RESISTANCE_DIG_MIN) begin
        resistance_dig <= `RESISTANCE_DIG_MIN; // see RULE12
      end else begin
        resistance_dig <= resistance_raw; // see RULE11, RULE12
      end
      velocity_dig <= velocity_raw; // see RULE10
    end
  end

  // ----------------------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (shadow_hit) begin
        reg_rdata <= shadow_flat[shadow_idx*`NVM_WORD_BITS +: `NVM_WORD_BITS];
      end else begin
        case (reg_addr)
          `OFS_EEPROM_ACCESS_KEY:        reg_rdata <= access_key_r;
          `OFS_EEPROM_READY_STATUS:      reg_rdata <= {15'h0000, ~busy}; // see RULE5
          `OFS_EEPROM_OPERATION_CONTROL: reg_rdata <= control_r;
          `OFS_DRIVER_DISABLE_CONTROL:   reg_rdata <= driver_disable_r;
          default:                       reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: common/nvm_access_regs.vh */
// register map, field positions and reset values of the parameter store access block
`ifndef NVM_ACCESS_REGS_VH
`define NVM_ACCESS_REGS_VH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_EEPROM_ACCESS_KEY        8'h31
`define OFS_EEPROM_READY_STATUS      8'h32
`define OFS_EEPROM_OPERATION_CONTROL 8'h35
`define OFS_DRIVER_DISABLE_CONTROL   8'h60
`define OFS_SHADOW_CONFIG_WORD_FIRST 8'h90
`define OFS_SHADOW_CONFIG_WORD_LAST  8'h96

// ----------------------------------------------------------------------------
// store geometry
// ----------------------------------------------------------------------------
`define NVM_WORDS                    7
`define NVM_WORD_BITS                16
`define NVM_TOTAL_BITS               112

// ----------------------------------------------------------------------------
// key sequence
// ----------------------------------------------------------------------------
`define KEY_CLEAR_VALUE              16'h0000
`define KEY_UNLOCK_VALUE             16'hC0DE

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define READY_FLAG_BIT               0
`define DRIVER_DISABLE_BIT           0
`define ACCESS_MODE_LSB              0
`define ACCESS_MODE_MSB              1
`define WRITE_SELECT_BIT             2
`define RELOAD_BIT                   3
`define SHADOW_ENABLE_BIT            4
`define ACCESS_MODE_MASS             2'h2
`define CONTROL_USED_MASK            16'h001F

// ----------------------------------------------------------------------------
// encoded motor parameter fields
// ----------------------------------------------------------------------------
`define PARAM_FIELD_MSB              6
`define PARAM_SHIFT_LSB              4
`define PARAM_MANT_MSB               3
`define RESISTANCE_DIG_MIN           11'h003

// ----------------------------------------------------------------------------
// reset values and default timing counts
// ----------------------------------------------------------------------------
`define RST_WORD                     16'h0000
`define RST_DRIVER_DISABLE           16'h0000
`define WORD_WRITE_CYCLES_DEF        8
`define WORD_READ_CYCLES_DEF         2

`endif

/* File: core/param_field_decode.v */
// shift-and-mantissa decoder for a 7-bit motor parameter field
`timescale 1ns/10ps
`default_nettype none
`include "nvm_access_regs.vh"

module param_field_decode (
  input  wire [6:0]  field_code,
  output wire [10:0] digital_value
);

  wire [10:0] mantissa_ext;

  // ----------------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------------
  assign mantissa_ext  = {7'h00, field_code[`PARAM_MANT_MSB:0]};
  // 0x7F gives 15 << 7 = 1920, the top of the range
  assign digital_value = mantissa_ext << field_code[`PARAM_FIELD_MSB:`PARAM_SHIFT_LSB]; // see RULE10

endmodule
`default_nettype wire

/* File: tb/nvm_access_chk.sv */
// assertion checker for the parameter store access block
`timescale 1ns/10ps
`default_nettype none
module nvm_access_chk #(
  parameter WORD_WRITE_CYCLES = 8,
  parameter WORD_READ_CYCLES  = 2
) (
  input wire        mclk,
  input wire        srst,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire        driver_stage_enable,
  input wire        nvm_ready_flag,
  input wire [10:0] resistance_dig,
  input wire [10:0] velocity_dig
);
  reg        armed_r;
  reg        open_r;
  reg [15:0] low_cnt_r;
  wire       op_req;
  assign op_req = reg_wr && reg_addr == 8'h35
                  && (reg_wdata[4:0] == 5'h02 || reg_wdata[4:0] == 5'h06);
  function [10:0] dec7(input [6:0] c);
    dec7 = {7'h00, c[3:0]} << c[6:4];
  endfunction
  // ----------------------------------------------------------------------------
  // key tracking and busy length counter
  // ----------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      armed_r   <= 1'b0;
      open_r    <= 1'b0;
      low_cnt_r <= 16'h0000;
    end else begin
      low_cnt_r <= nvm_ready_flag ? 16'h0000 : low_cnt_r + 16'h0001;
      if (reg_wr && reg_addr == 8'h31) begin
        armed_r <= reg_wdata == 16'h0000;
        open_r  <= armed_r && reg_wdata == 16'hC0DE;
      end
    end
  end
  // ----------------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  drv_follow_a: assert property (
    reg_wr && reg_addr == 8'h60 |=> driver_stage_enable == !$past(reg_wdata[0]))
    else $error("driver enable does not follow the disable bit");
  ready_read_a: assert property (
    reg_rd && reg_addr == 8'h32 |=> reg_rdata == {15'h0000, $past(nvm_ready_flag)})
    else $error("status read does not show the ready flag");
  start_ack_a: assert property (
    op_req && nvm_ready_flag && open_r |=> !nvm_ready_flag)
    else $error("valid request while unlocked did not start");
  start_cause_a: assert property (
    $fell(nvm_ready_flag) |-> $past(op_req && open_r))
    else $error("ready dropped without an unlocked request");
  busy_len_a: assert property (
    $rose(nvm_ready_flag) |->
      low_cnt_r == 7 * WORD_WRITE_CYCLES || low_cnt_r == 7 * WORD_READ_CYCLES)
    else $error("busy period has the wrong length");
  res_min_a: assert property (resistance_dig >= 11'h003)
    else $error("resistance below its floor");
  res_decode_a: assert property (
    reg_wr && reg_addr == 8'h90 && nvm_ready_flag |-> ##2 resistance_dig ==
      (dec7($past(reg_wdata[6:0], 2)) < 11'h003 ? 11'h003 : dec7($past(reg_wdata[6:0], 2))))
    else $error("resistance decode wrong");
  vel_decode_a: assert property (
    reg_wr && reg_addr == 8'h91 && nvm_ready_flag |-> ##2
      velocity_dig == dec7($past(reg_wdata[6:0], 2)))
    else $error("velocity decode wrong");
endmodule
bind nvm_param_access nvm_access_chk #(
  .WORD_WRITE_CYCLES (WORD_WRITE_CYCLES),
  .WORD_READ_CYCLES  (WORD_READ_CYCLES)
) chk (
  .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .driver_stage_enable(driver_stage_enable),
  .nvm_ready_flag(nvm_ready_flag), .resistance_dig(resistance_dig), .velocity_dig(velocity_dig)
);
`default_nettype wire

/* File: tb/host_model.sv */
// host controller model driving the register port of the parameter store block
`timescale 1ns/10ps
`default_nettype none
module host_model #(
  parameter WAKE_CYCLES = 500000
) (
  input  wire         mclk,
  input  wire  [15:0] reg_rdata,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end
  // settle time after power-up before the first register write
  task wake;
    repeat (WAKE_CYCLES) @(posedge mclk);
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge mclk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_wr    = 1'b0;
    // released lines flip so a stale value never passes for a held one
    reg_addr  = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  task rd(input [7:0] a, output [15:0] d);
    @(posedge mclk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~reg_addr;
    d        = reg_rdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/test_nvm_param_access.sv */
// self-checking testbench for the parameter store access block
`timescale 1ns/10ps
`default_nettype none
module test_nvm_param_access;
  logic        mclk;
  logic        srst;
  wire         reg_wr;
  wire         reg_rd;
  wire  [7:0]  reg_addr;
  wire  [15:0] reg_wdata;
  wire  [15:0] reg_rdata;
  wire         driver_stage_enable;
  wire         nvm_ready_flag;
  wire  [10:0] resistance_dig;
  wire  [10:0] velocity_dig;
  int          fails;
  int          check_count;
  logic [15:0] rv;
  logic [15:0] words [0:6] = '{16'h8001, 16'h4002, 16'h2004, 16'h1008, 16'h0810, 16'h0420, 16'hFFFF};
  logic [15:0] bad   [0:3] = '{16'h0006 | 16'h0010, 16'h000E, 16'h0001, 16'hFFEA};
  logic [6:0]  codes [0:4] = '{7'h00, 7'h01, 7'h04, 7'h2A, 7'h7F};
  logic [10:0] r_exp [0:4] = '{11'h003, 11'h003, 11'h004, 11'h028, 11'h780};
  logic [10:0] v_exp [0:4] = '{11'h000, 11'h001, 11'h004, 11'h028, 11'h780};
  nvm_param_access #(.WORD_WRITE_CYCLES(3), .WORD_READ_CYCLES(1)) dut (
    .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .driver_stage_enable(driver_stage_enable),
    .nvm_ready_flag(nvm_ready_flag), .resistance_dig(resistance_dig), .velocity_dig(velocity_dig)
  );
  host_model #(.WAKE_CYCLES(50)) host (
    .mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );
  task check(input [15:0] seen, input [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task rd_check(input [7:0] a, input [15:0] exp);
    host.rd(a, rv);
    check(rv, exp);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // polls status with a bound; running out counts as a mismatch
  task wait_ready;
    int n;
    n  = 0;
    rv = 16'h0000;
    while (rv[0] !== 1'b1 && n < 100) begin
      host.rd(8'h32, rv);
      n++;
    end
    if (rv[0] !== 1'b1) begin
      fails++;
      end_of_test;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    fails       = 0;
    check_count = 0;
    srst        = 1'b1;
    repeat (10) @(posedge mclk);
    #1 srst = 1'b0;
    host.wake;
    rd_check(8'h31, 16'h0000);
    rd_check(8'h32, 16'h0001);
    rd_check(8'h35, 16'h0000);
    rd_check(8'h60, 16'h0000);
    rd_check(8'h40, 16'h0000);
    check({5'h00, resistance_dig}, 16'h0003);
    host.wr(8'h60, 16'h0001);
    check({15'h0000, driver_stage_enable}, 16'h0000);
    rd_check(8'h60, 16'h0001);
    // key without the clearing write, then an interrupted sequence: both stay locked
    host.wr(8'h31, 16'hC0DE);
    host.wr(8'h35, 16'h0006);
    rd_check(8'h32, 16'h0001);
    host.wr(8'h31, 16'h0000);
    host.wr(8'h31, 16'h1234);
    host.wr(8'h31, 16'hC0DE);
    host.wr(8'h35, 16'h0002);
    rd_check(8'h32, 16'h0001);
    host.wr(8'h31, 16'h0000);
    host.wr(8'h31, 16'hC0DE);
    rd_check(8'h31, 16'hC0DE);
    foreach (bad[i]) begin
      host.wr(8'h35, bad[i]);
      rd_check(8'h32, 16'h0001);
    end
    rd_check(8'h35, 16'h000A);
    for (int i = 0; i < 7; i++) host.wr(8'h90 + 8'(i), words[i]);
    wait_ready;
    host.wr(8'h35, 16'h0006);
    rd_check(8'h32, 16'h0000);
    host.wr(8'h90, 16'h0BAD);
    host.wr(8'h35, 16'h0002);
    wait_ready;
    rd_check(8'h90, words[0]);
    for (int i = 0; i < 7; i++) host.wr(8'h90 + 8'(i), ~words[i]);
    host.wr(8'h35, 16'h0002);
    wait_ready;
    for (int i = 0; i < 7; i++) rd_check(8'h90 + 8'(i), words[i]);
    for (int i = 0; i < 5; i++) begin
      host.wr(8'h90, {9'h000, codes[i]});
      host.wr(8'h91, {9'h000, codes[i]});
      repeat (3) @(posedge mclk);
      #1;
      check({5'h00, resistance_dig}, {5'h00, r_exp[i]});
      check({5'h00, velocity_dig}, {5'h00, v_exp[i]});
    end
    host.wr(8'h60, 16'h0000);
    check({15'h0000, driver_stage_enable}, 16'h0001);
    end_of_test;
  end
endmodule
`default_nettype wire
